// ### adcc_top.sv
// ADC timing control and result computation with an AXI4-Lite register port.
// Assumes the analog core holds core_data stable while core_done is high,
// and that core_done and core_data arrive from outside the mclk domain.
`include "adcc_params.svh"

module adcc_top
(
   input wire logic mclk, // 125 MHz system clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic [15:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [15:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic core_done, // Analog core conversion done
   input wire logic [9:0] core_data, // Analog core raw sample
   output adcc_pkg::adcc_ana_t ana_r, // Controls to the analog core
   output logic thresh_check_r // Threshold check pulse
);
   import adcc_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge for register writes
   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            m[8*i +: 8] = nw[8*i +: 8];
      end
      return m;
   endfunction

   // Result placement by justify select
   function automatic logic [15:0] justify(input logic [9:0] d, input logic fm);
      return fm ? {6'h00, d} : {d, 6'h00};
   endfunction

   // Mapped register check
   function automatic logic mapped(input logic [15:0] a);
      logic [11:0] ix;
      ix = a[13:2];
      return (a[15:14] == 2'h0) && (ix == `ADCC_IDX_PRE || ix == `ADCC_IDX_ACQ ||
         ix == `ADCC_IDX_CAP || ix == `ADCC_IDX_PREV || ix == `ADCC_IDX_RES ||
         ix == `ADCC_IDX_RPT || ix == `ADCC_IDX_CNT || ix == `ADCC_IDX_ACC ||
         ix == `ADCC_IDX_FLT || ix == `ADCC_IDX_CTRL || ix == `ADCC_IDX_STAT);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] pre_r, acq_r, cap_r, rpt_r, cnt_r;
   logic [15:0] res_r, acc_r, flt_r, prev_r;
   logic [31:0] ctrl_r;
   logic aov_r, running_r, stage1_r, stage2_r, tick_r;
   logic [9:0] raw_r;
   logic [5:0] div_r;
   logic s1_done_r, s2_done_r, s3_done_r;
   logic [9:0] s1_data_r, s2_data_r;
   logic aw_hold_r, w_hold_r;
   logic [15:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   adcc_phase_t phase;
   logic conv_start, seq_done;

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   wire logic aw_fire = awvalid && awready;
   wire logic w_fire = wvalid && wready;
   wire logic wr_do = aw_hold_r && w_hold_r && !bvalid;
   wire logic aw_hold_nxt = (aw_hold_r || aw_fire) && !wr_do;
   wire logic w_hold_nxt = (w_hold_r || w_fire) && !wr_do;
   wire logic [11:0] wr_idx = awaddr_r[13:2];
   wire logic wr_ok = wr_do && mapped(awaddr_r);
   wire logic [31:0] res_merge = merge32({16'h0000, res_r}, wdata_r, wstrb_r);
   wire logic [31:0] acc_merge = merge32({16'h0000, acc_r}, wdata_r, wstrb_r);
   wire logic we_pre = wr_ok && wr_idx == `ADCC_IDX_PRE && wstrb_r[0];
   wire logic we_acq = wr_ok && wr_idx == `ADCC_IDX_ACQ && wstrb_r[0];
   wire logic we_cap = wr_ok && wr_idx == `ADCC_IDX_CAP && wstrb_r[0];
   wire logic we_rpt = wr_ok && wr_idx == `ADCC_IDX_RPT && wstrb_r[0];
   wire logic we_cnt = wr_ok && wr_idx == `ADCC_IDX_CNT && wstrb_r[0];
   wire logic we_res = wr_ok && wr_idx == `ADCC_IDX_RES;
   wire logic we_acc = wr_ok && wr_idx == `ADCC_IDX_ACC;
   wire logic we_ctrl = wr_ok && wr_idx == `ADCC_IDX_CTRL;
   wire logic aov_w1c = wr_ok && wr_idx == `ADCC_IDX_STAT && wstrb_r[0] &&
      wdata_r[`ADCC_STAT_AOV];

   // Address and data are held independently so either may arrive first
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `ADCC_RESP_OKAY;
         awaddr_r <= 16'h0000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end
      else
      begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready <= !aw_hold_nxt;
         wready <= !w_hold_nxt;
         if (aw_fire)
            awaddr_r <= awaddr;
         if (w_fire)
         begin
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (wr_do)
         begin
            bvalid <= 1'b1;
            bresp <= mapped(awaddr_r) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   wire logic ar_fire = arvalid && arready;
   wire logic rvalid_nxt = (rvalid && !rready) || ar_fire;
   wire logic [11:0] rd_idx = araddr[13:2];
   wire logic [31:0] rd_word =
      (rd_idx == `ADCC_IDX_PRE) ? {24'h000000, pre_r} :
      (rd_idx == `ADCC_IDX_ACQ) ? {24'h000000, acq_r} :
      (rd_idx == `ADCC_IDX_CAP) ? {27'h0000000, cap_r[4:0]} :
      (rd_idx == `ADCC_IDX_PREV) ? {16'h0000, prev_r} :
      (rd_idx == `ADCC_IDX_RES) ? {16'h0000, res_r} :
      (rd_idx == `ADCC_IDX_RPT) ? {24'h000000, rpt_r} :
      (rd_idx == `ADCC_IDX_CNT) ? {24'h000000, cnt_r} :
      (rd_idx == `ADCC_IDX_ACC) ? {16'h0000, acc_r} :
      (rd_idx == `ADCC_IDX_FLT) ? {16'h0000, flt_r} :
      (rd_idx == `ADCC_IDX_CTRL) ? ctrl_r :
      {28'h0000000, running_r, phase, aov_r};

   // Read answers one cycle after the address is taken
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `ADCC_RESP_OKAY;
      end
      else
      begin
         rvalid <= rvalid_nxt;
         arready <= !rvalid_nxt;
         if (ar_fire)
         begin
            rdata <= mapped(araddr) ? rd_word : 32'h00000000;
            rresp <= mapped(araddr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // A software set of go or clear lands after the hardware drop, so set wins
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pre_r <= `ADCC_RST_BYTE;
         acq_r <= `ADCC_RST_BYTE;
         cap_r <= `ADCC_RST_BYTE;
         rpt_r <= `ADCC_RST_BYTE;
         ctrl_r <= `ADCC_RST_CTRL;
      end
      else
      begin
         if (we_pre)
            pre_r <= wdata_r[7:0];
         if (we_acq)
            acq_r <= wdata_r[7:0];
         if (we_cap)
            cap_r <= {3'h0, wdata_r[4:0]};
         if (we_rpt)
            rpt_r <= wdata_r[7:0];
         if (ctrl_r[`ADCC_CTL_ACLR])
            ctrl_r[`ADCC_CTL_ACLR] <= 1'b0;
         if (seq_done)
            ctrl_r[`ADCC_CTL_GO] <= 1'b0;
         if (we_ctrl)
            ctrl_r <= merge32(ctrl_r, wdata_r, wstrb_r) & `ADCC_CTL_MASK;
      end
   end

   // ----------------------------------------
   // ADC clock enable and input synchronisers
   // ----------------------------------------
   // ADC clock rate is mclk / (div + 1)
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         div_r <= 6'h00;
         tick_r <= 1'b0;
         s1_done_r <= 1'b0;
         s2_done_r <= 1'b0;
         s3_done_r <= 1'b0;
         s1_data_r <= 10'h000;
         s2_data_r <= 10'h000;
      end
      else
      begin
         tick_r <= (div_r == 6'h00);
         div_r <= (div_r == 6'h00) ? ctrl_r[`ADCC_CTL_DIV] : div_r - 6'h01;
         s1_done_r <= core_done;
         s2_done_r <= s1_done_r;
         s3_done_r <= s2_done_r;
         s1_data_r <= core_data;
         s2_data_r <= s1_data_r;
      end
   end

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   // Start only on an ADC clock edge, so the first phase gets whole ADC clocks
   wire logic start = ctrl_r[`ADCC_CTL_GO] && !running_r && phase == SEQ_IDLE && tick_r;

   adcc_seq u_seq
   (
      .mclk(mclk),
      .rst(rst),
      .adc_tick(tick_r),
      .start(start),
      .precharge_clocks(pre_r),
      .acquisition_clocks(acq_r),
      .conv_done(s2_done_r && !s3_done_r),
      .phase_r(phase),
      .conv_start_r(conv_start),
      .done_r(seq_done)
   );

   // ----------------------------------------
   // Computation datapath
   // ----------------------------------------
   wire adcc_mode_t mode = adcc_mode_t'(ctrl_r[`ADCC_CTL_MODE]);
   wire logic [2:0] shift = ctrl_r[`ADCC_CTL_SHIFT];
   wire logic fm = ctrl_r[`ADCC_CTL_FM];
   wire logic rpt_mode = (mode == ADCC_MD_AVG || mode == ADCC_MD_BURST ||
      mode == ADCC_MD_LPF);
   wire logic acc_mode = (mode != ADCC_MD_BASIC);
   wire logic group_end = (cnt_r >= rpt_r);
   wire logic [7:0] cnt_next = group_end ? 8'h01 : cnt_r + 8'h01;
   wire logic [15:0] acc_base = (rpt_mode && group_end && mode != ADCC_MD_LPF) ?
      16'h0000 : (mode == ADCC_MD_LPF) ? acc_r - (acc_r >> shift) : acc_r;
   wire logic [16:0] acc_sum = {1'b0, acc_base} + {7'h00, raw_r};
   wire logic aclr = ctrl_r[`ADCC_CTL_ACLR];

   // Result at conversion end, then accumulator, then filter output
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         res_r <= `ADCC_RST_WORD;
         prev_r <= `ADCC_RST_WORD;
         acc_r <= `ADCC_RST_WORD;
         flt_r <= `ADCC_RST_WORD;
         cnt_r <= `ADCC_RST_BYTE;
         raw_r <= 10'h000;
         aov_r <= 1'b0;
         running_r <= 1'b0;
         stage1_r <= 1'b0;
         stage2_r <= 1'b0;
         thresh_check_r <= 1'b0;
      end
      else
      begin
         stage1_r <= seq_done;
         stage2_r <= stage1_r;
         thresh_check_r <= stage1_r && rpt_mode && cnt_next == rpt_r;
         if (start)
         begin
            running_r <= 1'b1;
            prev_r <= ctrl_r[`ADCC_CTL_PSIS] ? flt_r : justify(raw_r, fm);
         end
         if (seq_done)
         begin
            running_r <= 1'b0;
            raw_r <= s2_data_r;
            res_r <= justify(s2_data_r, fm);
         end
         else if (we_res)
            res_r <= res_merge[15:0];
         if (we_cnt)
            cnt_r <= wdata_r[7:0];
         if (we_acc)
            acc_r <= acc_merge[15:0];
         if (stage1_r && rpt_mode)
            cnt_r <= cnt_next;
         if (stage1_r && acc_mode)
            acc_r <= acc_sum[15:0];
         if (stage2_r && acc_mode)
            flt_r <= acc_r >> shift;
         aov_r <= (stage1_r && acc_mode && acc_sum[16]) || (aov_r && !aov_w1c && !aclr);
         if (aclr)
         begin
            acc_r <= 16'h0000;
            cnt_r <= 8'h00;
         end
      end
   end

   // Analog core controls, registered so each leaves from a flip-flop
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ana_r <= '0;
      else
         ana_r <= '{precharge_en: phase == SEQ_PRE, acquire_en: phase == SEQ_ACQ,
            convert_start: conv_start, extra_sample_cap: cap_r[4:0]};
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   pre_skip_a: assert property (start && pre_r == 8'h00 |=> phase != SEQ_PRE)
      else $error("precharge entered with zero length");
   pre_enter_a: assert property (start && pre_r != 8'h00 |=> ##1 ana_r.precharge_en)
      else $error("precharge not entered");
   acq_skip_a: assert property (phase == SEQ_PRE && acq_r == 8'h00 |=> phase != SEQ_ACQ)
      else $error("acquisition entered with zero length");
   cap_drive_a: assert property (##1 ana_r.extra_sample_cap == $past(cap_r[4:0]))
      else $error("extra capacitance not driven");
   cnt_idle_a: assert property (stage1_r && !rpt_mode && !aclr && !we_cnt
      |=> cnt_r == $past(cnt_r))
      else $error("repeat counter moved outside repeat modes");
   check_hit_a: assert property (stage1_r && rpt_mode && cnt_next == rpt_r
      |=> thresh_check_r)
      else $error("threshold check missed");
   flt_shift_a: assert property (stage2_r && acc_mode
      |=> flt_r == ($past(acc_r) >> $past(shift)))
      else $error("filter output not shifted accumulator");
   right_just_a: assert property (seq_done && fm |=> res_r[15:10] == 6'h00)
      else $error("right justify wrong");
   left_just_a: assert property (seq_done && !fm |=> res_r[5:0] == 6'h00)
      else $error("left justify wrong");
   prev_flt_a: assert property (start && ctrl_r[`ADCC_CTL_PSIS] |=> prev_r == $past(flt_r))
      else $error("previous result not filter output");
   clr_done_a: assert property (aclr && !we_ctrl
      |=> !aclr && acc_r == 16'h0000 && cnt_r == 8'h00)
      else $error("accumulator clear incomplete");

endmodule

// ### adcc_params.svh
// Register indices, field positions and reset values of the ADC control block.
// Assumes the byte address of a register is four times its index.
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ADCC_IDX_PRE 12'hF5E
`define ADCC_IDX_ACQ 12'hF5C
`define ADCC_IDX_CAP 12'hF5D
`define ADCC_IDX_PREV 12'hF61
`define ADCC_IDX_RES 12'hF63
`define ADCC_IDX_RPT 12'hF66
`define ADCC_IDX_CNT 12'hF67
`define ADCC_IDX_ACC 12'hF70
`define ADCC_IDX_FLT 12'hF72
`define ADCC_IDX_CTRL 12'hF80
`define ADCC_IDX_STAT 12'hF81

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define ADCC_CTL_MODE 2:0
`define ADCC_CTL_SHIFT 6:4
`define ADCC_CTL_FM 8
`define ADCC_CTL_PSIS 9
`define ADCC_CTL_ACLR 10
`define ADCC_CTL_GO 11
`define ADCC_CTL_DIV 21:16
`define ADCC_CTL_MASK 32'h003F0F77
`define ADCC_STAT_AOV 0

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define ADCC_RST_CTRL 32'h00000000
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_WORD 16'h0000
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

// ### adcc_pkg.sv
// Types shared by the ADC control block files.
// Assumes adcc_params.svh holds all numeric constants.
package adcc_pkg;

   // ----------------------------------------
   // Computation modes, in register encoding order
   // ----------------------------------------
   typedef enum logic [2:0] {ADCC_MD_BASIC, ADCC_MD_ACCUM, ADCC_MD_AVG, ADCC_MD_BURST,
      ADCC_MD_LPF} adcc_mode_t;

   // Conversion cycle phases
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_PRE, SEQ_ACQ, SEQ_CONV} adcc_phase_t;

   // Controls towards the analog core
   typedef struct packed {
      logic precharge_en;
      logic acquire_en;
      logic convert_start;
      logic [4:0] extra_sample_cap;
   } adcc_ana_t;

endpackage

// ### adcc_seq.sv
// Conversion cycle sequencer: precharge, acquisition, conversion.
// Assumes adc_tick is a one-cycle enable at the ADC clock rate and
// conv_done is a synchronised one-cycle completion pulse.
module adcc_seq
(
   input wire logic mclk, // System clock
   input wire logic rst, // Asynchronous reset
   input wire logic adc_tick, // ADC clock enable
   input wire logic start, // Begin a conversion cycle
   input wire logic [7:0] precharge_clocks, // Precharge length
   input wire logic [7:0] acquisition_clocks, // Acquisition length
   input wire logic conv_done, // Core finished
   output adcc_pkg::adcc_phase_t phase_r, // Current phase
   output logic conv_start_r, // Conversion start pulse
   output logic done_r // Cycle complete pulse
);
   import adcc_pkg::*;

   logic [7:0] left_r;

   // Phase entry decisions; a zero length skips the phase
   wire logic pre_on = (precharge_clocks != 8'h00);
   wire logic acq_on = (acquisition_clocks != 8'h00);
   wire logic last_tick = adc_tick && (left_r == 8'h01);

   // ----------------------------------------
   // Phase machine
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         phase_r <= SEQ_IDLE;
         left_r <= 8'h00;
         conv_start_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         conv_start_r <= 1'b0;
         done_r <= 1'b0;
         if (adc_tick && left_r != 8'h00)
            left_r <= left_r - 8'h01;
         case (phase_r)
            SEQ_IDLE:
               if (start && pre_on)
               begin
                  phase_r <= SEQ_PRE;
                  left_r <= precharge_clocks;
               end
               else if (start && acq_on)
               begin
                  phase_r <= SEQ_ACQ;
                  left_r <= acquisition_clocks;
               end
               else if (start)
               begin
                  phase_r <= SEQ_CONV;
                  conv_start_r <= 1'b1;
               end
            SEQ_PRE:
               if (last_tick && acq_on)
               begin
                  phase_r <= SEQ_ACQ;
                  left_r <= acquisition_clocks;
               end
               else if (last_tick)
               begin
                  phase_r <= SEQ_CONV;
                  conv_start_r <= 1'b1;
               end
            SEQ_ACQ:
               if (last_tick)
               begin
                  phase_r <= SEQ_CONV;
                  conv_start_r <= 1'b1;
               end
            SEQ_CONV:
               if (conv_done)
               begin
                  phase_r <= SEQ_IDLE;
                  done_r <= 1'b1;
               end
            default:
               phase_r <= SEQ_IDLE;
         endcase
      end
   end

endmodule

// ### adcc_core_model.sv
// Behavioural analog core that answers each conversion start with one sample.
// Assumes ana_r comes from adcc_top and the bench sets sample beforehand.
module adcc_core_model
(
   input wire logic mclk, // System clock
   input wire adcc_pkg::adcc_ana_t ana_r, // Controls from the block
   input wire logic [9:0] sample, // Value to return
   output logic core_done, // Conversion done level
   output logic [9:0] core_data, // Raw sample
   output logic [15:0] pre_n, // Precharge cycles of last cycle
   output logic [15:0] acq_n // Acquisition cycles of last cycle
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] pre_run = 16'h0;
   logic [15:0] acq_run = 16'h0;

   // ------
   // Phase lengths and a slow answer; data inverted outside the done window
   // ------
   initial
   begin
      core_done = 1'h0;
      core_data = 10'h3FF;
      pre_n = 16'h0;
      acq_n = 16'h0;
      forever
      begin
         @(posedge mclk);
         if (ana_r.precharge_en === 1'h1) pre_run++;
         if (ana_r.acquire_en === 1'h1) acq_run++;
         if (ana_r.convert_start === 1'h1)
         begin
            pre_n = pre_run;
            acq_n = acq_run;
            pre_run = 16'h0;
            acq_run = 16'h0;
            repeat (5) @(posedge mclk);
            core_data <= sample;
            core_done <= 1'h1;
            repeat (4) @(posedge mclk);
            core_done <= 1'h0;
            core_data <= ~sample;
         end
      end
   end
endmodule

// ### adc_timing_and_result_computation_test.sv
// Self-checking bench for adcc_top through AXI4-Lite register accesses.
// Assumes adcc_core_model answers every conversion start.
`include "adcc_params.svh"
module adc_timing_and_result_computation_test;
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic bready = 1'h1, rready = 1'h1;
   logic awready, wready, bvalid, arready, rvalid, core_done, thresh_check_r;
   logic [1:0] bresp, rresp, wresp;
   logic [31:0] rdata;
   logic [9:0] core_data, sample = 10'h0;
   logic [15:0] pre_n, acq_n;
   adcc_ana_t ana_r;
   int err_count = 0, check_count = 0, th_n = 0;

   adcc_top DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .core_done(core_done), .core_data(core_data), .ana_r(ana_r),
      .thresh_check_r(thresh_check_r));
   adcc_core_model core (.mclk(mclk), .ana_r(ana_r), .sample(sample),
      .core_done(core_done), .core_data(core_data), .pre_n(pre_n), .acq_n(acq_n));

   // Clock and threshold pulse count
   initial forever #4 mclk = ~mclk;
   always @(posedge mclk) if (thresh_check_r === 1'h1) th_n++;

   // ------
   // Bus tasks; ready lines held high so no strobe is driven twice in one step
   // ------
   function automatic logic [15:0] ba(input logic [11:0] i);
      return {2'h0, i, 2'h0};
   endfunction
   function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] sh,
      input logic fm, input logic ps);
      return {10'h0, 6'h01, 6'h0, ps, fm, 1'h0, sh, 1'h0, m};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      bit ta = 0;
      bit tw = 0;
      awaddr <= ba(i);
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(ta && tw))
      begin
         @(posedge mclk);
         if (awready === 1'h1 && !ta)
         begin
            ta = 1;
            awvalid <= 1'h0;
         end
         if (wready === 1'h1 && !tw)
         begin
            tw = 1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge mclk); while (bvalid !== 1'h1);
      wresp = bresp;
   endtask
   task automatic rd(input logic [11:0] i, output logic [31:0] d, output logic [1:0] r);
      araddr <= ba(i);
      arvalid <= 1'h1;
      do @(posedge mclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge mclk); while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
   endtask
   task automatic rc(input logic [11:0] i, input logic [31:0] e, input string n);
      logic [31:0] d;
      logic [1:0] r;
      rd(i, d, r);
      chk(n, e, d);
   endtask
   // Start a conversion and poll until go drops, bounded
   task automatic conv(input logic [31:0] c, input logic [9:0] s);
      logic [31:0] d = 32'h800;
      logic [1:0] r;
      int k = 0;
      sample <= s;
      wr(`ADCC_IDX_CTRL, c | 32'h0000_0800);
      while (d[11] !== 1'h0 && k < 100)
      begin
         rd(`ADCC_IDX_CTRL, d, r);
         k++;
      end
      chk("go", 32'h0, {31'h0, d[11]});
   endtask
   task automatic stop_test();
      $display("Checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk);
      err_count++;
      $display("ERROR watchdog expected finish seen timeout");
      stop_test();
   end

   // ------
   // Tests
   // ------
   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      repeat (2) @(posedge mclk);
      rc(`ADCC_IDX_RES, 32'h0, "result");
      rc(`ADCC_IDX_PREV, 32'h0, "previous");
      rd(12'hF00, d, r);
      chk("unmapped", {30'h0, `ADCC_RESP_SLVERR}, {d[29:0], r});
      wr(`ADCC_IDX_CAP, 32'h1F);
      @(posedge mclk);
      chk("cap", 32'h1F, {27'h0, ana_r.extra_sample_cap});
      wr(`ADCC_IDX_CAP, 32'h0);
      @(posedge mclk);
      chk("cap", 32'h0, {27'h0, ana_r.extra_sample_cap});
      wr(`ADCC_IDX_RPT, 32'hA5);
      chk("wresp", {30'h0, `ADCC_RESP_OKAY}, {30'h0, wresp});
      rc(`ADCC_IDX_RPT, 32'hA5, "target");
      wr(`ADCC_IDX_PRE, 32'h3);
      wr(`ADCC_IDX_ACQ, 32'h4);
      // Settle the ADC clock divider before the first timed conversion
      wr(`ADCC_IDX_CTRL, cw(ADCC_MD_BASIC, 3'h0, 1'h1, 1'h0));
      conv(cw(ADCC_MD_BASIC, 3'h0, 1'h1, 1'h0), 10'h2B5);
      chk("pre", 32'h6, pre_n);
      chk("acq", 32'h8, acq_n);
      rc(`ADCC_IDX_RES, 32'h02B5, "result");
      wr(`ADCC_IDX_PRE, 32'h0);
      wr(`ADCC_IDX_ACQ, 32'h0);
      conv(cw(ADCC_MD_BASIC, 3'h0, 1'h0, 1'h0), 10'h2B5);
      chk("pre", 32'h0, pre_n);
      chk("acq", 32'h0, acq_n);
      rc(`ADCC_IDX_RES, 32'hAD40, "result");
      wr(`ADCC_IDX_PRE, 32'h1);
      wr(`ADCC_IDX_CTRL, cw(ADCC_MD_ACCUM, 3'h2, 1'h1, 1'h0) | 32'h400);
      rc(`ADCC_IDX_ACC, 32'h0, "accum");
      rc(`ADCC_IDX_CNT, 32'h0, "count");
      conv(cw(ADCC_MD_ACCUM, 3'h2, 1'h1, 1'h0), 10'h2B5);
      chk("pre", 32'h2, pre_n);
      chk("acq", 32'h0, acq_n);
      conv(cw(ADCC_MD_ACCUM, 3'h2, 1'h1, 1'h0), 10'h100);
      rc(`ADCC_IDX_RES, 32'h0100, "result");
      rc(`ADCC_IDX_ACC, 32'h03B5, "accum");
      rc(`ADCC_IDX_FLT, 32'h00ED, "filter");
      rc(`ADCC_IDX_PREV, 32'h02B5, "previous");
      conv(cw(ADCC_MD_ACCUM, 3'h2, 1'h1, 1'h1), 10'h100);
      rc(`ADCC_IDX_PREV, 32'h00ED, "previous");
      rc(`ADCC_IDX_FLT, 32'h012D, "filter");
      chk("checks", 32'h0, th_n);
      wr(`ADCC_IDX_RPT, 32'h2);
      wr(`ADCC_IDX_CTRL, cw(ADCC_MD_AVG, 3'h1, 1'h1, 1'h0) | 32'h400);
      rc(`ADCC_IDX_ACC, 32'h0, "accum");
      conv(cw(ADCC_MD_AVG, 3'h1, 1'h1, 1'h0), 10'h100);
      conv(cw(ADCC_MD_AVG, 3'h1, 1'h1, 1'h0), 10'h100);
      rc(`ADCC_IDX_CNT, 32'h2, "count");
      chk("checks", 32'h1, th_n);
      conv(cw(ADCC_MD_BURST, 3'h1, 1'h1, 1'h0), 10'h100);
      rc(`ADCC_IDX_CNT, 32'h1, "count");
      wr(`ADCC_IDX_CTRL, cw(ADCC_MD_LPF, 3'h1, 1'h1, 1'h0) | 32'h400);
      rc(`ADCC_IDX_CNT, 32'h0, "count");
      conv(cw(ADCC_MD_LPF, 3'h1, 1'h1, 1'h0), 10'h100);
      rc(`ADCC_IDX_FLT, 32'h0080, "filter");
      stop_test();
   end
endmodule
